// ### inc/rmcs_pkg.sv
// Package for the relay matrix channel selector: register map, field layout,
// reset values and the encodings of modes and module types.
// Assumes a 32-bit classic Wishbone register bus and a 2 x 12 relay module.
package rmcs_pkg;

  // Relay module geometry.
  localparam int RMCS_RELAYS = 12;
  localparam int RMCS_UNITS = 16;
  localparam logic [9:0] RMCS_CH_MIN = 10'h001;
  localparam logic [9:0] RMCS_CH_MAX = 10'h0C0;

  // Wishbone address layout: word index, then unit address, then side.
  localparam int RMCS_ADR_W = 12;
  localparam int RMCS_IDX_LSB = 2;
  localparam int RMCS_IDX_MSB = 5;
  localparam int RMCS_UNIT_LSB = 6;
  localparam int RMCS_UNIT_MSB = 9;
  localparam int RMCS_SIDE_BIT = 10;

  // Register byte offsets inside one unit.
  localparam logic [5:0] RMCS_IN_A_CH = 6'h00;
  localparam logic [5:0] RMCS_IN_B_CH = 6'h04;
  localparam logic [5:0] RMCS_OUT_A_CH = 6'h08;
  localparam logic [5:0] RMCS_OUT_B_CH = 6'h0C;
  localparam logic [5:0] RMCS_OUT_MODE = 6'h10;
  localparam logic [5:0] RMCS_IO_OFFSET = 6'h14;
  localparam logic [5:0] RMCS_AB_OFFSET = 6'h18;
  localparam logic [5:0] RMCS_SWEEP_CTRL = 6'h1C;
  localparam logic [5:0] RMCS_SWEEP_POINT = 6'h20;
  localparam logic [5:0] RMCS_RELAY_STATE = 6'h24;
  localparam logic [5:0] RMCS_UNIT_CONFIG = 6'h28;

  // Sweep control fields.
  localparam int RMCS_SW_ACTIVE = 0;
  localparam int RMCS_SW_A_IN = 1;
  localparam int RMCS_SW_B_IN = 2;
  localparam int RMCS_SW_A_OUT = 3;
  localparam int RMCS_SW_B_OUT = 4;

  // Field positions of the readback registers.
  localparam int RMCS_RS_B_LSB = 12;
  localparam int RMCS_RS_BRK_LSB = 24;
  localparam int RMCS_CFG_TYPE_LSB = 4;
  localparam int RMCS_CFG_SIDE_BIT = 6;
  localparam int RMCS_CFG_OUTSIDE_BIT = 8;

  // Reset values.
  localparam logic [7:0] RMCS_CH_RST = 8'h00;
  localparam logic [7:0] RMCS_OFF_RST = 8'h00;
  localparam logic [4:0] RMCS_SWEEP_RST = 5'h00;
  localparam logic [31:0] RMCS_DATA_ZERO = 32'h0000_0000;

  // Output relationship modes; the reset value is the independent mode.
  typedef enum logic [1:0] {
    RMCS_MODE_INDEP,
    RMCS_MODE_ALL,
    RMCS_MODE_ALL_BUT_ONE,
    RMCS_MODE_SPARE
  } rmcs_mode_t;

  // Module flavour as set by the unit's own configuration switches.
  typedef enum logic [1:0] {
    RMCS_TYPE_OUTPUT,
    RMCS_TYPE_INPUT,
    RMCS_TYPE_PATCH,
    RMCS_TYPE_UNBAL
  } rmcs_type_t;

endpackage

// ### hdl/rmcs_top.sv
// Channel selector for one 2 x 12 relay module in a stacked switcher system.
// Assumes a classic Wishbone master on the shared control bus, straps that are
// static, and relay drivers that close a relay while its output bit is high.
// How it works
// - Two commons onto twelve relays, sixteen-unit stack.
// - Input A and B channels span 1..192.
// - Output A and B channels span 1..192.
// - Unit answers only its twelve-channel block.
// - Zero or foreign channel connects nothing.
// - Static selections rule unless sweep active.
// - Sweep end restores static connections exactly.
// - Independent mode sets A, B freely; default.
// - All-driven mode: B everywhere, A off.
// - All-driven mode ignores output channel selections, except for the patch break relays.
// - All-but-one: A selected, B all others.
// - Swept output equals input plus offset.
// - Swept B equals A plus offset.
// - Output unit fans generator commons out.
// - Patch unit breaks path while relay operated.
// - Unbalanced unit side chosen by strap.
// - Unit responds only to its own address.
// - Four-bit 8-4-2-1 address picks channel block.
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps

module rmcs_top
  import rmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [RMCS_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] unit_addr_i,
  input wire logic [1:0] unit_type_i,
  input wire logic unbal_output_i,
  output logic [RMCS_RELAYS-1:0] relay_a_o,
  output logic [RMCS_RELAYS-1:0] relay_b_o,
  output logic [RMCS_RELAYS-1:0] patch_break_o
);

  // Turns a signed channel number into a one-hot relay word for this unit.
  function automatic logic [RMCS_RELAYS-1:0] rmcs_decode(input logic [9:0] ch, input logic [3:0] unit);
    logic [7:0] idx;
    logic [7:0] blk;
    logic [7:0] rel;
    logic [RMCS_RELAYS-1:0] hot;
    idx = 8'h00;
    blk = 8'h00;
    rel = 8'h00;
    hot = '0;
    if (!ch[9] && ch >= RMCS_CH_MIN && ch <= RMCS_CH_MAX) begin
      idx = ch[7:0] - 8'h01;
      blk = idx / 8'h0C;
      rel = idx % 8'h0C;
      if (blk == {4'h0, unit}) begin
        hot = 12'h001 << rel[3:0];
      end
    end
    return hot;
  endfunction

  // Straps are resampled every cycle; under reset they take constants only.
  logic [3:0] unit_addr_r;
  rmcs_type_t unit_type_r;
  logic unbal_output_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_addr_r <= 4'h0;
      unit_type_r <= RMCS_TYPE_OUTPUT;
      unbal_output_r <= 1'b0;
    end else begin
      unit_addr_r <= unit_addr_i;
      unit_type_r <= rmcs_type_t'(unit_type_i);
      unbal_output_r <= unbal_output_i;
    end
  end

  // Which side this unit serves; a patch unit follows the output selections.
  wire is_output_side = (unit_type_r == RMCS_TYPE_OUTPUT) || (unit_type_r == RMCS_TYPE_PATCH) ||
    ((unit_type_r == RMCS_TYPE_UNBAL) && unbal_output_r);

  // Bus decode: the side and unit fields must name this very unit.
  wire [3:0] adr_unit = wb_adr_i[RMCS_UNIT_MSB:RMCS_UNIT_LSB];
  wire adr_side = wb_adr_i[RMCS_SIDE_BIT];
  wire [5:0] adr_off = {wb_adr_i[RMCS_IDX_MSB:RMCS_IDX_LSB], 2'b00};
  wire unit_hit = (adr_unit == unit_addr_r) && (adr_side == is_output_side);
  wire req = wb_cyc_i && wb_stb_i && unit_hit && !wb_ack_o;
  wire wr = req && wb_we_i && wb_sel_i[0];

  // Software-visible registers.
  logic [7:0] in_a_r;
  logic [7:0] in_b_r;
  logic [7:0] out_a_r;
  logic [7:0] out_b_r;
  rmcs_mode_t mode_r;
  logic [7:0] io_off_r;
  logic [7:0] ab_off_r;
  logic [4:0] sweep_r;
  logic [7:0] point_r;

  // Only the low byte lane carries the narrow fields, so sel bit 0 gates writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_a_r <= RMCS_CH_RST;
      in_b_r <= RMCS_CH_RST;
      out_a_r <= RMCS_CH_RST;
      out_b_r <= RMCS_CH_RST;
      mode_r <= RMCS_MODE_INDEP;
      io_off_r <= RMCS_OFF_RST;
      ab_off_r <= RMCS_OFF_RST;
      sweep_r <= RMCS_SWEEP_RST;
      point_r <= RMCS_CH_RST;
    end else if (wr) begin
      case (adr_off)
        RMCS_IN_A_CH: in_a_r <= wb_dat_i[7:0];
        RMCS_IN_B_CH: in_b_r <= wb_dat_i[7:0];
        RMCS_OUT_A_CH: out_a_r <= wb_dat_i[7:0];
        RMCS_OUT_B_CH: out_b_r <= wb_dat_i[7:0];
        RMCS_OUT_MODE: mode_r <= rmcs_mode_t'(wb_dat_i[1:0]);
        RMCS_IO_OFFSET: io_off_r <= wb_dat_i[7:0];
        RMCS_AB_OFFSET: ab_off_r <= wb_dat_i[7:0];
        RMCS_SWEEP_CTRL: sweep_r <= wb_dat_i[4:0];
        RMCS_SWEEP_POINT: point_r <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // Sweep arithmetic in ten signed bits, so a negative or oversized sum simply decodes to nothing.
  wire sweep_on = sweep_r[RMCS_SW_ACTIVE];
  wire sw_a_in = sweep_r[RMCS_SW_A_IN];
  wire sw_b_in = sweep_r[RMCS_SW_B_IN];
  wire sw_a_out = sweep_r[RMCS_SW_A_OUT];
  wire sw_b_out = sweep_r[RMCS_SW_B_OUT];
  wire [9:0] pt_w = {2'b00, point_r};
  wire [9:0] io_w = {{2{io_off_r[7]}}, io_off_r};
  wire [9:0] ab_w = {{2{ab_off_r[7]}}, ab_off_r};
  wire a_swept = sw_a_in || sw_a_out;
  wire in_swept = sw_a_in || sw_b_in;
  wire [9:0] b_base = a_swept ? (pt_w + ab_w) : pt_w;
  wire [9:0] a_out_sw = in_swept ? (pt_w + io_w) : pt_w;
  wire [9:0] b_out_sw = in_swept ? (b_base + io_w) : b_base;

  // Each common line takes the swept value only while the sweep runs and names it.
  wire [9:0] in_a_eff = (sweep_on && sw_a_in) ? pt_w : {2'b00, in_a_r};
  wire [9:0] in_b_eff = (sweep_on && sw_b_in) ? b_base : {2'b00, in_b_r};
  wire [9:0] out_a_eff = (sweep_on && sw_a_out) ? a_out_sw : {2'b00, out_a_r};
  wire [9:0] out_b_eff = (sweep_on && sw_b_out) ? b_out_sw : {2'b00, out_b_r};

  // One-hot relay words for every line as seen by this unit.
  wire [RMCS_RELAYS-1:0] in_a_hot = rmcs_decode(in_a_eff, unit_addr_r);
  wire [RMCS_RELAYS-1:0] in_b_hot = rmcs_decode(in_b_eff, unit_addr_r);
  wire [RMCS_RELAYS-1:0] out_a_hot = rmcs_decode(out_a_eff, unit_addr_r);
  wire [RMCS_RELAYS-1:0] out_b_hot = rmcs_decode(out_b_eff, unit_addr_r);

  // Output-side relay words per mode; the all-driven mode never looks at the channel fields.
  logic [RMCS_RELAYS-1:0] out_a_nxt;
  logic [RMCS_RELAYS-1:0] out_b_nxt;

  always_comb begin
    out_a_nxt = out_a_hot;
    out_b_nxt = out_b_hot;
    case (mode_r)
      RMCS_MODE_ALL: begin
        out_a_nxt = '0;
        out_b_nxt = '1;
      end
      RMCS_MODE_ALL_BUT_ONE: begin
        out_a_nxt = out_a_hot;
        out_b_nxt = ~out_a_hot;
      end
      default: begin
      end
    endcase
  end

  // Final drive words; a patch unit operates its insertion relays instead of the commons.
  wire is_patch = (unit_type_r == RMCS_TYPE_PATCH);
  wire [RMCS_RELAYS-1:0] relay_a_nxt = is_patch ? '0 : (is_output_side ? out_a_nxt : in_a_hot);
  wire [RMCS_RELAYS-1:0] relay_b_nxt = is_patch ? '0 : (is_output_side ? out_b_nxt : in_b_hot);
  wire [RMCS_RELAYS-1:0] break_nxt = is_patch ? (out_a_hot | out_b_hot) : '0;

  // Relay drivers are registered so that the relay coils never see decode glitches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      relay_a_o <= '0;
      relay_b_o <= '0;
      patch_break_o <= '0;
    end else begin
      relay_a_o <= relay_a_nxt;
      relay_b_o <= relay_b_nxt;
      patch_break_o <= break_nxt;
    end
  end

  // Read mux; an unmapped offset inside this unit reads as zero so the master never hangs.
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = RMCS_DATA_ZERO;
    case (adr_off)
      RMCS_IN_A_CH: rd_nxt = {24'h000000, in_a_r};
      RMCS_IN_B_CH: rd_nxt = {24'h000000, in_b_r};
      RMCS_OUT_A_CH: rd_nxt = {24'h000000, out_a_r};
      RMCS_OUT_B_CH: rd_nxt = {24'h000000, out_b_r};
      RMCS_OUT_MODE: rd_nxt = {30'h00000000, mode_r};
      RMCS_IO_OFFSET: rd_nxt = {24'h000000, io_off_r};
      RMCS_AB_OFFSET: rd_nxt = {24'h000000, ab_off_r};
      RMCS_SWEEP_CTRL: rd_nxt = {27'h0000000, sweep_r};
      RMCS_SWEEP_POINT: rd_nxt = {24'h000000, point_r};
      RMCS_RELAY_STATE: rd_nxt = {8'h00, relay_b_o | patch_break_o, relay_a_o} & 32'h00FF_FFFF;
      RMCS_UNIT_CONFIG: rd_nxt = {23'h000000, is_output_side, 1'b0, unbal_output_r, unit_type_r, unit_addr_r};
      default: rd_nxt = RMCS_DATA_ZERO;
    endcase
  end

  // Ack one cycle after the request and drop it the next; another unit's address gets no ack here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RMCS_DATA_ZERO;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_nxt : RMCS_DATA_ZERO;
    end
  end

endmodule // rmcs_top

// ### verification/rmcs_checker_assertions.sv
// Checker for the relay channel selector: bus timing and relay shapes.
// Assumes it is bound to rmcs_top and sees only its ports.
`timescale 1ns/1ps

module rmcs_checker
  import rmcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] unit_type_i,
  input wire logic [RMCS_RELAYS-1:0] relay_a_o,
  input wire logic [RMCS_RELAYS-1:0] relay_b_o,
  input wire logic [RMCS_RELAYS-1:0] patch_break_o
);
  // One clock domain; reset masks every property.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without a request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_reset_clears: assert property ($fell(rst_i) |-> relay_a_o == '0 && relay_b_o == '0)
    else $error("relays closed after reset");
  a_relay_a_single: assert property ($onehot0(relay_a_o))
    else $error("common A on more than one channel");
  a_patch_no_common: assert property ((unit_type_i == RMCS_TYPE_PATCH) [*3] |=> relay_a_o == '0 && relay_b_o == '0)
    else $error("patch unit drives a common");
  a_nonpatch_no_break: assert property ((unit_type_i != RMCS_TYPE_PATCH) [*3] |=> patch_break_o == '0)
    else $error("break relay on a non patch unit");
  a_input_b_single: assert property ((unit_type_i == RMCS_TYPE_INPUT) [*3] |=> $onehot0(relay_b_o))
    else $error("input unit B on several channels");
endmodule // rmcs_checker

bind rmcs_top rmcs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unit_type_i(unit_type_i), .relay_a_o(relay_a_o),
  .relay_b_o(relay_b_o), .patch_break_o(patch_break_o));

// ### verification/rmcs_host_model.sv
// Host model: a classic Wishbone master issuing single accesses.
// Assumes one caller at a time and a registered ack from the unit.
`timescale 1ns/1ps

module rmcs_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o = 1'b0,
  output logic wb_stb_o = 1'b0,
  output logic wb_we_o = 1'b0,
  output logic [11:0] wb_adr_o = 12'h000,
  output logic [3:0] wb_sel_o = 4'h0,
  output logic [31:0] wb_dat_o = 32'h0000_0000
);
  // Stereo pairs sit on adjacent channels, so sweep points advance by two.
  function automatic logic [7:0] pair_point(input logic [7:0] k);
    return 8'h02 * k + 8'h01;
  endfunction

  // Request held until ack is sampled; the loop bound guards against a hang.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output bit ok);
    int n;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
    wb_adr_o <= a;
    wb_dat_o <= d;
    wb_sel_o <= 4'hF;
    ok = 1'b0;
    r = 32'h0000_0000;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_i);
      ok = (wb_ack_i === 1'b1);
      r = wb_dat_i;
    end
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
  endtask
endmodule // rmcs_host_model

// ### verification/tb_relay_matrix_channel_selector.sv
// Testbench: register scenarios through the host model, relays read back.
// Assumes one unit whose straps the bench drives, on a 50 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module tb_relay_matrix_channel_selector
  import rmcs_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] utype = 2'h0;
  logic unbal = 1'b0;
  logic cyc, stb, we, ack;
  logic [3:0] sel;
  logic [11:0] adr, ra, rb, rp;
  logic [31:0] wdat, rdat;
  int error_cnt = 0;
  int checked = 0;
  logic [3:0] uaddr = 4'h1;
  bit nak_ok;
  logic [31:0] nak_r;
  // Decode table: an output A channel and the A relay word it gives on unit 1.
  logic [7:0] chs [6] = '{8'h0D, 8'h18, 8'h0C, 8'h00, 8'h19, 8'hC1};
  logic [11:0] exp_a [6] = '{12'h001, 12'h800, 12'h000, 12'h000, 12'h000, 12'h000};

  // Half period of 10 ns.
  always #10 clk_i = ~clk_i;

  rmcs_host_model host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  rmcs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .unit_addr_i(uaddr),
    .unit_type_i(utype), .unbal_output_i(unbal), .relay_a_o(ra), .relay_b_o(rb), .patch_break_o(rp));

  // Verdict and exit in one place.
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A missing ack counts as a mismatch and ends the run.
  task automatic acc(input logic w, input logic s, input logic [5:0] o, input logic [31:0] d,
    output logic [31:0] r);
    bit ok;
    host.xfer(w, {1'b0, s, uaddr, o}, d, r, ok);
    if (!ok) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic s, input logic [5:0] o, input logic [7:0] d);
    logic [31:0] r;
    acc(1'b1, s, o, {24'h00_0000, d}, r);
  endtask

  task automatic rc(input logic s, input logic [5:0] o, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, s, o, 32'h0000_0000, r);
    `CHK(r, e)
  endtask

  // Main sequence; each relay check follows a full access or a four-cycle wait, so the relays have settled.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rc(1'b1, RMCS_RELAY_STATE, 32'h0000_0000);
    rc(1'b1, RMCS_UNIT_CONFIG, 32'h0000_0101);
    rc(1'b1, 6'h3C, 32'h0000_0000);
    $display("test reset done");
    wr(1'b1, RMCS_OUT_B_CH, 8'h18);
    for (int i = 0; i < 6; i++) begin
      wr(1'b1, RMCS_OUT_A_CH, chs[i]);
      rc(1'b1, RMCS_RELAY_STATE, {8'h00, 12'h800, exp_a[i]});
    end
    $display("test decode done");
    wr(1'b1, RMCS_OUT_MODE, 8'h01);
    rc(1'b1, RMCS_RELAY_STATE, 32'h00FF_F000);
    wr(1'b1, RMCS_OUT_A_CH, 8'h0E);
    rc(1'b1, RMCS_RELAY_STATE, 32'h00FF_F000);
    wr(1'b1, RMCS_OUT_MODE, 8'h02);
    rc(1'b1, RMCS_RELAY_STATE, 32'h00FF_D002);
    wr(1'b1, RMCS_OUT_MODE, 8'h03);
    rc(1'b1, RMCS_RELAY_STATE, 32'h0080_0002);
    wr(1'b1, RMCS_OUT_MODE, 8'h00);
    $display("test modes done");
    wr(1'b1, RMCS_IO_OFFSET, 8'hFF);
    wr(1'b1, RMCS_AB_OFFSET, 8'h01);
    wr(1'b1, RMCS_SWEEP_POINT, host.pair_point(8'h08));
    wr(1'b1, RMCS_SWEEP_CTRL, 8'h1B);
    rc(1'b1, RMCS_RELAY_STATE, 32'h0001_0008);
    wr(1'b1, RMCS_SWEEP_CTRL, 8'h00);
    rc(1'b1, RMCS_RELAY_STATE, 32'h0080_0002);
    `CHK({rb, ra}, 24'h800002)
    $display("test sweep done");
    utype <= RMCS_TYPE_PATCH;
    repeat (4) @(posedge clk_i);
    `CHK({rp, rb, ra}, 36'h802000000)
    utype <= RMCS_TYPE_INPUT;
    repeat (4) @(posedge clk_i);
    wr(1'b0, RMCS_IN_A_CH, 8'h0D);
    wr(1'b0, RMCS_IN_B_CH, 8'h0F);
    rc(1'b0, RMCS_RELAY_STATE, 32'h0000_4001);
    utype <= RMCS_TYPE_UNBAL;
    unbal <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(1'b1, RMCS_UNIT_CONFIG, 32'h0000_0171);
    rc(1'b1, RMCS_RELAY_STATE, 32'h0080_0002);
    unbal <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(1'b0, RMCS_RELAY_STATE, 32'h0000_4001);
    $display("test types done");
    // Unit 0 answers channels 1..12 only; the unit 1 selections must vanish from it.
    uaddr <= 4'h0;
    repeat (4) @(posedge clk_i);
    rc(1'b0, RMCS_UNIT_CONFIG, 32'h0000_0030);
    rc(1'b0, RMCS_RELAY_STATE, 32'h0000_0000);
    wr(1'b0, RMCS_IN_A_CH, 8'h0C);
    rc(1'b0, RMCS_RELAY_STATE, 32'h0000_0800);
    // A write to another unit's address must get no ack and change nothing here.
    host.xfer(1'b1, {2'b00, 4'h3, RMCS_IN_B_CH}, 32'h0000_0001, nak_r, nak_ok);
    `CHK(nak_ok, 1'b0)
    rc(1'b0, RMCS_IN_B_CH, 32'h0000_000F);
    $display("test address done");
    end_of_test();
  end
endmodule // tb_relay_matrix_channel_selector
